/* File: design/search_coproc_pkg.sv */
package search_coproc_pkg;

	// Descriptor ring
	localparam int DESC_COUNT        = 32;
	localparam int DESC_AW           = 5;
	localparam int ALMOST_FULL_LEVEL = 30;

	// Host port address layout: {ring/cfg, descriptor[4:0], word[1:0]}
	localparam int         ADDR_W      = 8;
	localparam int         ADDR_CFG_BIT = 7;
	localparam int         ADDR_DESC_LSB = 2;
	localparam logic [1:0] WORD_CMD    = 2'h0;
	localparam logic [1:0] WORD_PARAM  = 2'h1;
	localparam logic [1:0] WORD_RES0   = 2'h2;
	localparam logic [1:0] WORD_RES1   = 2'h3;
	localparam logic [7:0] CFG_ADDR    = 8'h80;

	// Configuration register
	localparam int         CFG_W                = 3;
	localparam int         CFG_SOFT_RESET_BIT   = 0;
	localparam int         CFG_HIT_IN_DATA_BIT  = 1;
	localparam int         CFG_ASSOC_ENGINE_BIT = 2;
	localparam logic [2:0] CFG_RESET            = 3'h0;

	// Command word
	localparam int         CMD_START_BIT = 63;
	localparam int         CMD_PROC_LSB  = 32;
	localparam int         CMD_CTX_LSB   = 24;
	localparam int         CMD_OP_LSB    = 0;
	localparam int         OP_W          = 8;
	localparam logic [7:0] OP_SEARCH     = 8'h01;

	// Result word zero / one
	localparam int RES_DONE_BIT  = 31;
	localparam int RES_HIT_BIT   = 30;
	localparam int RES_CTX_LSB   = 24;
	localparam int RES_PROC_LSB  = 32;
	localparam int ID_W          = 5;
	localparam int INDEX_W       = 24;
	localparam int DATA_HIT_BIT  = 63;
	localparam int CID_PROC_BITS = 3;

	// Interface select encodings
	localparam logic [2:0] IFC_PIPE_ZERO_TURN = 3'h0;
	localparam logic [2:0] IFC_FLOW_ZERO_TURN = 3'h1;
	localparam logic [2:0] IFC_BURST_EARLY    = 3'h2;
	localparam logic [2:0] IFC_BURST_LATE     = 3'h3;

	// Internal soft reset duration
	localparam int CLK_PERIOD_NS     = 10;
	localparam int SOFT_RESET_NS     = 160;
	localparam int SOFT_RESET_CYCLES = (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : search_coproc_pkg

/* File: design/desc_order_fifo.sv */
module desc_order_fifo #(
	parameter int WIDTH = 5,
	parameter int DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             flush,
	input  wire logic             push,
	input  wire logic [WIDTH-1:0] pushData,
	input  wire logic             pop,
	output logic      [WIDTH-1:0] head,
	output logic                  empty,
	output logic                  full
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW:0]      wrPtr_q;
	logic [PW:0]      rdPtr_q;

	assign empty = (wrPtr_q == rdPtr_q);
	assign full  = (wrPtr_q[PW-1:0] == rdPtr_q[PW-1:0]) && (wrPtr_q[PW] != rdPtr_q[PW]);
	assign head  = mem[rdPtr_q[PW-1:0]];

	always_ff @(posedge clk) begin
		if (push && !full) begin
			mem[wrPtr_q[PW-1:0]] <= pushData;
		end
	end

	// Pointers carry one wrap bit so full and empty never alias
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
		end else if (flush) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
		end else begin
			if (push && !full) begin
				wrPtr_q <= wrPtr_q + 1'b1;
			end
			if (pop && !empty) begin
				rdPtr_q <= rdPtr_q + 1'b1;
			end
		end
	end

endmodule : desc_order_fifo

/* File: design/search_coproc_host_port.sv */
// Function
// - Search status word: done, hit, ids
// - Engine-side data returned in word one; a miss reads zero unless the hit flag is in bit 63
// - Optional hit flag in data bit 63
// - Reading result word zero clears done
// - Host-side data: index in word zero
// - Index meaningful only when hit set
// - Index fields; unused top bits read zero
// - Thirty-two descriptors, thirty-two outstanding operations
// - Almost-full output at thirty occupied descriptors
// - Start bit queues descriptor for execution
// - Queued commands execute first in, first out
// - Results written to issuing descriptor, then done
// - Completion id bus and one-cycle strobe
// - Select pins choose host port protocol
// - Pipelined mode: data two cycles after address
// - New access every cycle, no turnaround
// - Flow-through mode: data one cycle later
// - Non-search commands report done at bit 31
module search_coproc_host_port
	import search_coproc_pkg::*;
#(
	parameter int INDEX_USED_BITS = 22
) (
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic [2:0]          interfaceSelectPins,
	input  wire logic                chipEnable_n,
	input  wire logic                chipEnableSecond,
	input  wire logic                chipEnableThird_n,
	input  wire logic                readWrite_n,
	input  wire logic [7:0]          byteWrite_n,
	input  wire logic                globalByteWrite_n,
	input  wire logic [ADDR_W-1:0]   address,
	input  wire logic [63:0]         dataIn,
	output logic      [63:0]         dataOut,
	output logic                     dataOe_n,
	output logic                     ringAlmostFull,
	output logic      [7:0]          completionIdBus,
	output logic                     completionStrobe,
	output logic                     engReqValid,
	output logic      [63:0]         engReqCommand,
	output logic      [63:0]         engReqParam,
	input  wire logic                engReqReady,
	input  wire logic                engRspValid,
	input  wire logic                engRspHit,
	input  wire logic [63:0]         engRspData,
	input  wire logic [INDEX_W-1:0]  engRspIndex
);
	typedef enum logic [1:0] {EX_IDLE, EX_ISSUE, EX_WAIT, EX_POST} exState_t;

	////////////////////////////////////////////////////////////////////////////////
	// Host port pipeline
	logic              modeOk, latOne, sel;
	logic              s1Valid_q, s1Write_q, s2Valid_q, s2Write_q;
	logic [ADDR_W-1:0] s1Addr_q, s2Addr_q;
	logic [7:0]        s1Be_q, s2Be_q;
	logic              rdFire, wrFire;
	logic [ADDR_W-1:0] rdAddr, wrAddr;
	logic [7:0]        wrBe_n;

	// The global byte-write input is not used by any supported mode
	assign modeOk = (interfaceSelectPins <= IFC_BURST_LATE);
	assign latOne = (interfaceSelectPins != IFC_PIPE_ZERO_TURN);
	assign sel    = modeOk && !chipEnable_n && chipEnableSecond && !chipEnableThird_n;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1Valid_q <= 1'b0;
			s1Write_q <= 1'b0;
			s1Addr_q  <= '0;
			s1Be_q    <= 8'hFF;
			s2Valid_q <= 1'b0;
			s2Write_q <= 1'b0;
			s2Addr_q  <= '0;
			s2Be_q    <= 8'hFF;
		end else begin
			s1Valid_q <= sel;
			s1Write_q <= !readWrite_n;
			s1Addr_q  <= address;
			s1Be_q    <= byteWrite_n;
			s2Valid_q <= s1Valid_q;
			s2Write_q <= s1Write_q;
			s2Addr_q  <= s1Addr_q;
			s2Be_q    <= s1Be_q;
		end
	end

	// Reads complete one edge before the host samples; writes take data at their own edge
	assign rdFire = latOne ? (sel && readWrite_n) : (s1Valid_q && !s1Write_q);
	assign rdAddr = latOne ? address : s1Addr_q;
	assign wrFire = latOne ? (s1Valid_q && s1Write_q) : (s2Valid_q && s2Write_q);
	assign wrAddr = latOne ? s1Addr_q : s2Addr_q;
	assign wrBe_n = latOne ? s1Be_q : s2Be_q;

	function automatic logic [63:0] mergeBytes(input logic [63:0] old, input logic [63:0] nw,
		input logic [7:0] be_n);
		logic [63:0] r;
		r = old;
		for (int b = 0; b < 8; b++) begin
			if (!be_n[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction : mergeBytes

	////////////////////////////////////////////////////////////////////////////////
	// Descriptor storage and flags
	logic [63:0]        cmdMem   [DESC_COUNT];
	logic [63:0]        paramMem [DESC_COUNT];
	logic [63:0]        res0Mem  [DESC_COUNT];
	logic [63:0]        res1Mem  [DESC_COUNT];
	logic [DESC_COUNT-1:0] busy_q, done_q;
	logic [CFG_W-1:0]   cfg_q;
	logic [4:0]         srCount_q;
	logic               swReset;
	logic [DESC_AW-1:0] wrDesc, rdDesc, curDesc_q, fifoHead;
	logic               wrRing, wrCmd, startReq, rdRes0;
	logic [63:0]        newCmd;
	logic               doneSet, fifoEmpty, fifoPop;
	exState_t           state_q;
	logic [5:0]         occCount;

	assign swReset  = cfg_q[CFG_SOFT_RESET_BIT];
	assign wrDesc   = wrAddr[ADDR_DESC_LSB +: DESC_AW];
	assign rdDesc   = rdAddr[ADDR_DESC_LSB +: DESC_AW];
	assign wrRing   = wrFire && !wrAddr[ADDR_CFG_BIT] && !swReset;
	// A busy descriptor refuses host writes until its result is collected
	assign wrCmd    = wrRing && (wrAddr[1:0] == WORD_CMD) && !busy_q[wrDesc];
	assign newCmd   = mergeBytes(cmdMem[wrDesc], dataIn, wrBe_n);
	assign startReq = wrCmd && newCmd[CMD_START_BIT];
	assign rdRes0   = rdFire && !rdAddr[ADDR_CFG_BIT] && (rdAddr[1:0] == WORD_RES0);

	always_ff @(posedge clk) begin
		if (wrCmd) begin
			cmdMem[wrDesc] <= newCmd;
		end
		if (wrRing && (wrAddr[1:0] == WORD_PARAM) && !busy_q[wrDesc]) begin
			paramMem[wrDesc] <= mergeBytes(paramMem[wrDesc], dataIn, wrBe_n);
		end
	end

	// Done: hardware set wins over a same-cycle clearing read; busy: a host start wins over a clearing read
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_q <= '0;
			done_q <= '0;
		end else if (swReset) begin
			busy_q <= '0;
			done_q <= '0;
		end else begin
			for (int i = 0; i < DESC_COUNT; i++) begin
				if ((startReq && wrDesc == i) || (rdRes0 && rdDesc == i && done_q[i])) begin
					busy_q[i] <= startReq && wrDesc == i;
				end
				if (doneSet && curDesc_q == i) begin
					done_q[i] <= 1'b1;
				end else if (rdRes0 && rdDesc == i) begin
					done_q[i] <= 1'b0;
				end
			end
		end
	end

	always_comb begin
		occCount = '0;
		for (int i = 0; i < DESC_COUNT; i++) begin
			occCount = occCount + {5'h00, busy_q[i]};
		end
	end

	// Configuration and self-clearing soft reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q     <= CFG_RESET;
			srCount_q <= '0;
		end else if (wrFire && wrAddr == CFG_ADDR && !swReset) begin
			cfg_q     <= CFG_W'(mergeBytes({{(64-CFG_W){1'b0}}, cfg_q}, dataIn, wrBe_n));
			srCount_q <= 5'(SOFT_RESET_CYCLES);
		end else if (swReset) begin
			if (srCount_q <= 5'h01) begin
				cfg_q[CFG_SOFT_RESET_BIT] <= 1'b0;
			end
			srCount_q <= srCount_q - 5'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Execution queue and engine sequencing
	desc_order_fifo #(
		.WIDTH (DESC_AW),
		.DEPTH (DESC_COUNT)
	) u_order (
		.clk      (clk),
		.rst_n    (rst_n),
		.flush    (swReset),
		.push     (startReq),
		.pushData (wrDesc),
		.pop      (fifoPop),
		.head     (fifoHead),
		.empty    (fifoEmpty),
		.full     ()
	);

	assign fifoPop = (state_q == EX_IDLE) && !fifoEmpty && !swReset;
	assign doneSet = (state_q == EX_WAIT) && engRspValid && !swReset;

	function automatic logic [63:0] statusWord(input logic [63:0] cmd, input logic hit,
		input logic [INDEX_W-1:0] idx, input logic engineSide);
		logic [63:0] r;
		r = '0;
		r[RES_PROC_LSB +: ID_W] = cmd[CMD_PROC_LSB +: ID_W];
		r[RES_CTX_LSB +: ID_W]  = cmd[CMD_CTX_LSB +: ID_W];
		if (cmd[CMD_OP_LSB +: OP_W] == OP_SEARCH) begin
			r[RES_HIT_BIT] = hit;
			if (!engineSide && hit) begin
				r[INDEX_USED_BITS-1:0] = idx[INDEX_USED_BITS-1:0];
			end
		end
		return r;
	endfunction : statusWord

	always_ff @(posedge clk) begin
		if (doneSet) begin
			// Done itself lives in done_q and is merged on read
			res0Mem[curDesc_q] <= statusWord(engReqCommand, engRspHit, engRspIndex,
				cfg_q[CFG_ASSOC_ENGINE_BIT]);
			if (engReqCommand[CMD_OP_LSB +: OP_W] != OP_SEARCH || !cfg_q[CFG_ASSOC_ENGINE_BIT]) begin
				res1Mem[curDesc_q] <= '0;
			end else if (cfg_q[CFG_HIT_IN_DATA_BIT]) begin
				res1Mem[curDesc_q] <= {engRspHit, engRspData[DATA_HIT_BIT-1:0]};
			end else begin
				res1Mem[curDesc_q] <= engRspHit ? engRspData : 64'h0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q          <= EX_IDLE;
			curDesc_q        <= '0;
			engReqValid      <= 1'b0;
			engReqCommand    <= '0;
			engReqParam      <= '0;
			completionStrobe <= 1'b0;
			completionIdBus  <= '0;
		end else if (swReset) begin
			state_q          <= EX_IDLE;
			engReqValid      <= 1'b0;
			completionStrobe <= 1'b0;
		end else begin
			completionStrobe <= 1'b0;
			case (state_q)
				EX_IDLE: begin
					if (fifoPop) begin
						curDesc_q     <= fifoHead;
						engReqCommand <= cmdMem[fifoHead];
						engReqParam   <= paramMem[fifoHead];
						engReqValid   <= 1'b1;
						state_q       <= EX_ISSUE;
					end
				end
				EX_ISSUE: begin
					if (engReqReady) begin
						engReqValid <= 1'b0;
						state_q     <= EX_WAIT;
					end
				end
				EX_WAIT: begin
					if (engRspValid) begin
						state_q <= EX_POST;
					end
				end
				EX_POST: begin
					// Strobe follows done by one edge so a woken context always sees done set
					completionStrobe <= 1'b1;
					completionIdBus  <= {engReqCommand[CMD_PROC_LSB +: CID_PROC_BITS],
						engReqCommand[CMD_CTX_LSB +: ID_W]};
					state_q          <= EX_IDLE;
				end
				default: begin
					state_q <= EX_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data and status outputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dataOut        <= '0;
			dataOe_n       <= 1'b1;
			ringAlmostFull <= 1'b0;
		end else begin
			dataOe_n       <= !rdFire;
			ringAlmostFull <= (occCount >= 6'(ALMOST_FULL_LEVEL));
			if (!rdFire) begin
				dataOut <= '0;
			end else if (rdAddr[ADDR_CFG_BIT]) begin
				dataOut <= (rdAddr == CFG_ADDR) ? {{(64-CFG_W){1'b0}}, cfg_q} : 64'h0;
			end else begin
				case (rdAddr[1:0])
					WORD_CMD:   dataOut <= cmdMem[rdDesc];
					WORD_PARAM: dataOut <= paramMem[rdDesc];
					WORD_RES0:  dataOut <= res0Mem[rdDesc] | (64'(done_q[rdDesc]) << RES_DONE_BIT);
					default:    dataOut <= res1Mem[rdDesc];
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	sequence pipeRead;
		sel && readWrite_n && interfaceSelectPins == IFC_PIPE_ZERO_TURN
		##1 interfaceSelectPins == IFC_PIPE_ZERO_TURN;
	endsequence

	sequence searchDone;
		doneSet && engReqCommand[CMD_OP_LSB +: OP_W] == OP_SEARCH;
	endsequence

	a_strobe_after_done: assert property (@(posedge clk) disable iff (!rst_n)
		doneSet |=> done_q[curDesc_q] ##1 completionStrobe ##1 !completionStrobe)
		else $error("completion strobe not one cycle after done");

	a_almost_full_level: assert property (@(posedge clk) disable iff (!rst_n)
		(occCount >= 6'(ALMOST_FULL_LEVEL)) |=> ringAlmostFull)
		else $error("almost full not raised at thirty");

	a_read_clears_done: assert property (@(posedge clk) disable iff (!rst_n)
		(rdRes0 && !(doneSet && curDesc_q == rdDesc) && !swReset) |=> !done_q[$past(rdDesc)])
		else $error("result read did not clear done");

	a_start_queues_desc: assert property (@(posedge clk) disable iff (!rst_n)
		startReq |=> busy_q[$past(wrDesc)] && !fifoEmpty)
		else $error("started descriptor not queued");

	a_pipe_read_latency: assert property (@(posedge clk) disable iff (!rst_n)
		pipeRead |=> !dataOe_n)
		else $error("pipelined read data not two cycles after address");

	a_flow_read_latency: assert property (@(posedge clk) disable iff (!rst_n)
		(sel && readWrite_n && latOne) |=> !dataOe_n ##1 (dataOe_n || $past(rdFire)))
		else $error("flow-through read data not one cycle after address");

	a_soft_reset_ends: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(swReset) |-> ##[1:20] !swReset)
		else $error("soft reset bit did not self-clear");

	a_search_hit_word: assert property (@(posedge clk) disable iff (!rst_n)
		searchDone |=> res0Mem[curDesc_q][RES_HIT_BIT] == $past(engRspHit))
		else $error("hit flag not stored in result word zero");

	a_hit_in_data_bit: assert property (@(posedge clk) disable iff (!rst_n)
		(searchDone and cfg_q[CFG_ASSOC_ENGINE_BIT] && cfg_q[CFG_HIT_IN_DATA_BIT])
		|=> res1Mem[curDesc_q][DATA_HIT_BIT] == $past(engRspHit))
		else $error("hit not placed in data bit 63");

endmodule : search_coproc_host_port

/* File: dv/search_engine_model.sv */
module search_engine_model (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        engReqValid,
	input  wire logic [63:0] engReqParam,
	output logic             engReqReady,
	output logic             engRspValid,
	output logic             engRspHit,
	output logic      [63:0] engRspData,
	output logic      [23:0] engRspIndex
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [63:0] p;
	////////////////////////////////////////////////////////////////
	// Param bit 0 picks hit, bits 11:8 the answer delay
	// Outside a response the lines carry inverted values, so stale data never looks valid
	initial begin
		{engReqReady, engRspValid, engRspHit, p} = '0;
		engRspData  = '1;
		engRspIndex = '1;
		forever begin
			@(negedge clk);
			if (rst_n && engReqValid) begin
				engReqReady = 1'b1;
				p           = engReqParam;
				@(negedge clk);
				engReqReady = 1'b0;
				repeat (p[11:8]) @(negedge clk);
				{engRspValid, engRspHit, engRspData, engRspIndex} = {1'b1, p[0], ~p, p[47:24]};
				@(negedge clk);
				{engRspValid, engRspHit, engRspData, engRspIndex} = {1'b0, ~p[0], p, ~p[47:24]};
			end
		end
	end
endmodule : search_engine_model

/* File: dv/search_coproc_host_port_tb.sv */
module search_coproc_host_port_tb;
	import search_coproc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0, rst_n = 0, ceN = 1, ce2 = 0, ce3N = 1, rwN = 1;
	logic        oeN, aFull, strobe, reqV, rdy, rv, rh;
	logic [2:0]  mode = 3'h1;
	logic [7:0]  bwN = 8'hFF, addr = 8'h00, cid;
	logic [63:0] din = '0, dout, par, rdat;
	logic [23:0] ridx;
	logic [7:0]  ids [$];
	logic [2:0]  cfgTab [6] = '{3'h4, 3'h6, 3'h6, 3'h0, 3'h0, 3'h4};
	int          n_mismatch = 0, n_compared = 0, cycles = 0, lat = 1;

	search_coproc_host_port search_coproc_host_port_i (.clk(clk), .rst_n(rst_n),
		.interfaceSelectPins(mode), .chipEnable_n(ceN), .chipEnableSecond(ce2),
		.chipEnableThird_n(ce3N), .readWrite_n(rwN), .byteWrite_n(bwN), .globalByteWrite_n(1'b1),
		.address(addr), .dataIn(din), .dataOut(dout), .dataOe_n(oeN), .ringAlmostFull(aFull),
		.completionIdBus(cid), .completionStrobe(strobe), .engReqValid(reqV), .engReqCommand(),
		.engReqParam(par), .engReqReady(rdy), .engRspValid(rv), .engRspHit(rh),
		.engRspData(rdat), .engRspIndex(ridx));
	search_engine_model search_engine_model_i (.clk(clk), .rst_n(rst_n), .engReqValid(reqV),
		.engReqParam(par), .engReqReady(rdy), .engRspValid(rv), .engRspHit(rh),
		.engRspData(rdat), .engRspIndex(ridx));

	always #5 clk = ~clk;
	// Strobe is launched on the rising edge, so it is taken mid-cycle where it has settled
	always @(negedge clk) begin
		cycles++;
		if (strobe === 1'b1) ids.push_back(cid);
		if (cycles == 20000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk

	// Up to two back-to-back accesses; data lanes follow the mode's latency
	task automatic acc(input logic wr, input logic [7:0] a0, a1, input logic [63:0] d0, d1,
		input int n, output logic [63:0] q);
		for (int i = 0; i <= lat + n; i++) begin
			@(negedge clk);
			if (i == lat && !wr) q = (oeN === 1'b0) ? dout : 'x;
			{ceN, ce2, ce3N} = (i < n) ? 3'b010 : 3'b101;
			rwN  = ~wr;
			bwN  = wr ? 8'h00 : 8'hFF;
			addr = (i == 0) ? a0 : a1;
			din  = (i == lat) ? d0 : (i == lat + 1) ? d1 : ~d0;
		end
	endtask : acc

	task automatic wr(input logic [7:0] a, input logic [63:0] d);
		logic [63:0] q;
		acc(1'b1, a, a, d, d, 1, q);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [63:0] q);
		acc(1'b0, a, a, '0, '0, 1, q);
	endtask : rd

	function automatic logic [7:0] ad(input logic [4:0] d, input logic [1:0] w);
		return {1'b0, d, w};
	endfunction : ad

	// Parameter first, start bit only in the final write
	task automatic post(input logic [4:0] d, pr, input logic [7:0] op, input logic [63:0] p);
		logic [63:0] q;
		acc(1'b1, ad(d, WORD_PARAM), ad(d, WORD_CMD), p, {1'b1, 26'h0, pr, 3'h0, d, 16'h0, op}, 2, q);
	endtask : post

	task automatic setMode(input logic [2:0] m);
		@(negedge clk);
		mode = m;
		lat  = (m == 3'h0) ? 2 : 1;
	endtask : setMode

	task automatic waitIds(input int n);
		for (int i = 0; i < 400 && ids.size() < n; i++) @(negedge clk);
		chk("completions", 64'(ids.size()), 64'(n));
	endtask : waitIds
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [63:0] q;
		chk("oe idle", 64'(oeN), 64'h1);
		chk("strobe idle", 64'(strobe), 64'h0);
		chk("req idle", 64'(reqV), 64'h0);
		rd(CFG_ADDR, q);
		chk("cfg reset", q, 64'(CFG_RESET));
		rd(8'h84, q);
		chk("unmapped", q, 64'h0);
	endtask : t_reset

	task automatic t_boot();
		logic [63:0] q;
		wr(CFG_ADDR, 64'h5);
		rd(CFG_ADDR, q);
		chk("soft reset busy", 64'(q[0]), 64'h1);
		repeat (32) @(negedge clk);
		rd(CFG_ADDR, q);
		chk("soft reset done", q, 64'h4);
	endtask : t_boot

	task automatic t_modes();
		logic [63:0] q;
		for (int m = 0; m < 4; m++) begin
			setMode(3'(m));
			wr(CFG_ADDR, 64'(m * 2));
			rd(CFG_ADDR, q);
			chk("cfg via mode", q, 64'(m * 2));
		end
		setMode(3'h5);
		wr(CFG_ADDR, 64'h2);
		rd(CFG_ADDR, q);
		chk("reserved read", q, 'x);
		setMode(3'h1);
		rd(CFG_ADDR, q);
		chk("reserved write", q, 64'h6);
	endtask : t_modes

	task automatic t_results();
		logic [63:0] p, q, e0, e1, m0, m1;
		logic [2:0]  cfg;
		logic [7:0]  op;
		logic [4:0]  d, pr;
		logic        hit, srch;
		int          n;
		for (int k = 0; k < 6; k++) begin
			cfg = cfgTab[k];
			hit = k != 2 && k != 4;
			op  = (k == 5) ? 8'h02 : OP_SEARCH;
			setMode(k[0] ? 3'h0 : 3'h1);
			wr(CFG_ADDR, 64'(cfg));
			d  = 5'(k + 1);
			pr = 5'(k + 3);
			p  = {16'h9A5C, 24'hFFC123, 12'h0, 4'(k), 7'h35, hit};
			n  = ids.size();
			post(d, pr, op, p);
			waitIds(n + 1);
			chk("completion id", 64'(cid), 64'({pr[2:0], d}));
			srch = op == OP_SEARCH;
			e0   = (64'(pr) << 32) | (64'(d) << 24) | (64'h1 << 31) | (64'(srch & hit) << 30);
			if (srch && !cfg[2] && hit) e0 |= 64'(p[45:24]);
			// Index of a miss carries no meaning, so it is masked out
			m0   = (srch && !cfg[2] && !hit) ? ~64'hFF_FFFF : '1;
			e1   = (srch && cfg[2] && (hit || cfg[1])) ? {cfg[1] ? hit : ~p[63], ~p[62:0]} : '0;
			m1   = (cfg[1] && !hit) ? 64'h8000_0000_0000_0000 : '1;
			rd(ad(d, WORD_RES0), q);
			chk("result0", q & m0, e0 & m0);
			rd(ad(d, WORD_RES1), q);
			chk("result1", q & m1, e1 & m1);
			rd(ad(d, WORD_RES0), q);
			chk("done cleared", 64'(q[31]), 64'h0);
		end
	endtask : t_results

	task automatic t_ring();
		logic [63:0] q;
		logic [4:0]  d;
		setMode(3'h2);
		wr(CFG_ADDR, 64'h4);
		ids.delete();
		// An answer delay of eight lets the queue fill, so start order really matters
		for (int i = 0; i < 32; i++) begin
			post(5'(i * 7), 5'(i), OP_SEARCH, 64'h801);
			repeat (2) @(negedge clk);
			if (i == 28 || i == 29) chk("almost full", 64'(aFull), 64'(i == 29));
		end
		waitIds(32);
		for (int i = 0; i < 32; i++) begin
			d = 5'(i * 7);
			chk("order", 64'(ids[i]), 64'({3'(i), d}));
			rd(ad(d, WORD_RES0), q);
			chk("done", 64'(q[31]), 64'h1);
		end
		repeat (2) @(negedge clk);
		chk("almost full", 64'(aFull), 64'h0);
	endtask : t_ring

	task automatic tally_and_finish();
		if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (16) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		t_reset();
		t_boot();
		t_modes();
		t_results();
		t_ring();
		tally_and_finish();
	end
endmodule : search_coproc_host_port_tb
